// [include/ccp_pkg.sv]
// Package: constants and carriers for the CAN config and transmit priority block
package ccp_pkg;
  localparam int NBUF = 3;
  localparam int NACC = 8;
  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_CTL0   = 8'h00;
  localparam logic [7:0] OFS_CTL1   = 8'h04;
  localparam logic [7:0] OFS_BTR0   = 8'h08;
  localparam logic [7:0] OFS_BTR1   = 8'h0C;
  localparam logic [7:0] OFS_IDAC   = 8'h10;
  localparam logic [7:0] OFS_TBSEL  = 8'h14;
  localparam logic [7:0] OFS_TX_BUFFER_LOCAL_PRIORITY   = 8'h18;
  localparam logic [7:0] OFS_TFLG   = 8'h1C;
  localparam logic [7:0] OFS_ERRCNT = 8'h20;
  localparam logic [7:0] OFS_TSTX   = 8'h24;
  localparam logic [7:0] OFS_TSRX   = 8'h28;
  localparam logic [7:0] OFS_DLC    = 8'h2C;
  localparam logic [7:0] OFS_IRQST  = 8'h30;
  localparam logic [7:0] OFS_IRQMSK = 8'h34;
  localparam logic [7:0] OFS_ARB    = 8'h38;
  localparam logic [7:0] OFS_IDAR   = 8'h40;
  localparam logic [7:0] OFS_IDMR   = 8'h60;
  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int B_INIT_REQUEST_BIT = 0;
  localparam int B_SLEEP_REQUEST_BIT  = 1;
  localparam int B_WAKEUP_ENABLE_BIT   = 2;
  localparam int B_TIME   = 3;
  localparam int B_INIT_ACK_FLAG = 0;
  localparam int B_SLEEP_ACK_FLAG  = 1;
  localparam int B_CLOCK_SOURCE_SELECT = 6;
  localparam int B_ENABLE = 7;
  localparam int SJW_HI   = 7;
  localparam int SJW_LO   = 6;
  localparam int BRP_HI   = 5;
  localparam int IRQ_TXDONE = 0;
  localparam int IRQ_INIT   = 1;
  localparam int IRQ_SLEEP  = 2;
  localparam int IRQ_WAKE   = 3;
  localparam int NIRQ       = 4;
  localparam logic [7:0] CTL0_RST  = 8'h01;
  localparam logic [7:0] CTL0_WMSK = 8'h0F;
  localparam logic [3:0] DLC_MAX   = 4'h8;
  // ************************************************************
  // Carriers between this block and the protocol engine
  // ************************************************************
  typedef struct packed {
    logic sof_pending;
    logic ack_seen;
    logic ack_is_tx;
    logic tx_done;
    logic bus_idle;
    logic bus_activity;
    logic tx_bit;
    logic osc_tick;
  } ccp_proto_in_t;
  typedef struct packed {
    logic       sel_valid;
    logic [1:0] sel_idx;
    logic [3:0] byte_count;
    logic [2:0] sjw_tq;
    logic       tq_tick;
    logic       ctl_enabled;
  } ccp_proto_out_t;
  // Codes above eight still carry eight data bytes
  function automatic logic [3:0] dlc_bytes(input logic [3:0] code);
    dlc_bytes = (code > DLC_MAX) ? DLC_MAX : code;
  endfunction : dlc_bytes
endpackage : ccp_pkg

// [design/ccp_quantum_gen.sv]
// Time quantum tick generator with clock source choice
`timescale 1ns/100ps
`default_nettype none
module ccp_quantum_gen (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       src_bus,
  input  wire logic       osc_tick,
  input  wire logic [5:0] prescale,
  output logic            tq_tick
);
  import ccp_pkg::*;
  logic [5:0] cnt_q;
  logic       src_ev;
  assign src_ev  = src_bus | osc_tick;
  assign tq_tick = src_ev & (cnt_q >= prescale);
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_q <= 6'h00;
    end else if (tq_tick) begin
      cnt_q <= 6'h00;
    end else if (src_ev) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
  a_tick_after_count: assert property (@(posedge mclk) disable iff (!rstn)
    tq_tick && $stable(prescale) |=> !tq_tick || prescale == 6'h00)
    else $error("quantum tick repeated with nonzero prescale");
  a_osc_gates_count: assert property (@(posedge mclk) disable iff (!rstn)
    !src_bus && !osc_tick |=> $stable(cnt_q))
    else $error("prescaler advanced without a source edge");
endmodule : ccp_quantum_gen
`default_nettype wire

// [design/ccp_local_priority_field_arb.sv]
// Local priority selection among pending transmit buffers
`timescale 1ns/100ps
`default_nettype none
module ccp_local_priority_field_arb (
  input  wire logic [ccp_pkg::NBUF-1:0]      pend,
  input  wire logic [ccp_pkg::NBUF-1:0][7:0] local_priority_field,
  output logic                               valid,
  output logic [1:0]                         idx
);
  import ccp_pkg::*;
  always_comb begin
    valid = 1'b0;
    idx   = 2'h0;
    // Strict compare keeps the lowest index on a tie
    for (int i = 0; i < NBUF; i++) begin
      if (pend[i] && (!valid || local_priority_field[i] < local_priority_field[idx])) begin
        valid = 1'b1;
        idx   = 2'(i);
      end
    end
  end
endmodule : ccp_local_priority_field_arb
`default_nettype wire

// [design/ccp_ctrl.sv]
// CAN controller configuration lock, mode handshakes and transmit priority
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module ccp_ctrl (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire logic [7:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire ccp_pkg::ccp_proto_in_t proto_in,
  input  wire logic [7:0]             tec,
  input  wire logic [7:0]             rec,
  output ccp_pkg::ccp_proto_out_t     proto_out,
  output logic                        bus_transmit_pin,
  output logic                        irq
);
  import ccp_pkg::*;
  typedef enum logic [1:0] {MODE_RUN, MODE_INIT, MODE_SLEEP} ccp_mode_t;

  // ************************************************************
  // State
  // ************************************************************
  ccp_mode_t                  mode_q;
  logic [7:0]                 ctl0_q;
  logic                       en_q;
  logic                       en_locked_q;
  logic                       clock_source_select_q;
  logic [7:0]                 btr0_q;
  logic [7:0]                 btr1_q;
  logic [7:0]                 idac_q;
  logic [NACC-1:0][7:0]       idar_q;
  logic [NACC-1:0][7:0]       idmr_q;
  logic [1:0]                 tbsel_q;
  logic [NBUF-1:0][7:0]       local_priority_field_q;
  logic [NBUF-1:0][3:0]       dlc_q;
  logic [NBUF-1:0]            empty_q;
  logic [NBUF-1:0][15:0]      ts_tx_q;
  logic [15:0]                ts_rx_q;
  logic [15:0]                timer_q;
  logic [NIRQ-1:0]            irq_st_q;
  logic [NIRQ-1:0]            irq_msk_q;
  logic                       win_valid_q;
  logic [1:0]                 win_idx_q;
  logic                       ack_q;
  logic [31:0]                rdata_q;
  logic                       txpin_q;
  logic [31:0]                rd_d;
  logic [NIRQ-1:0]            ev;
  logic                       acc;
  logic                       wr_en;
  logic                       rd_done;
  logic                       init_mode;
  logic                       sel_ok;
  logic                       arb_valid;
  logic [1:0]                 arb_idx;
  logic                       tq_tick;
  logic                       wake;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ************************************************************
  // Bus slave: one wait cycle, then answer
  // ************************************************************
  assign acc             = avs_read | avs_write;
  assign avs_waitrequest = acc & ~ack_q;
  assign wr_en           = avs_write & ack_q;
  assign rd_done         = avs_read & ack_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc & ~ack_q;
      if (avs_read && !ack_q) begin
        rdata_q <= rd_d;
      end
    end
  end

  assign init_mode = ctl0_q[B_INIT_REQUEST_BIT] & (mode_q == MODE_INIT);
  assign sel_ok    = (tbsel_q < 2'(NBUF)) && empty_q[tbsel_q];
  assign wake      = (mode_q == MODE_SLEEP) & ctl0_q[B_WAKEUP_ENABLE_BIT] & proto_in.bus_activity;

  always_comb begin
    rd_d = 32'h0000_0000;
    case (1'b1)
      hit(avs_address, OFS_CTL0):   rd_d[7:0] = ctl0_q;
      hit(avs_address, OFS_CTL1): begin
        rd_d[B_ENABLE] = en_q;
        rd_d[B_CLOCK_SOURCE_SELECT] = clock_source_select_q;
        rd_d[B_SLEEP_ACK_FLAG]  = (mode_q == MODE_SLEEP);
        rd_d[B_INIT_ACK_FLAG] = (mode_q == MODE_INIT);
      end
      hit(avs_address, OFS_BTR0):   rd_d[7:0] = btr0_q;
      hit(avs_address, OFS_BTR1):   rd_d[7:0] = btr1_q;
      hit(avs_address, OFS_IDAC):   rd_d[7:0] = idac_q;
      hit(avs_address, OFS_TBSEL):  rd_d[1:0] = tbsel_q;
      hit(avs_address, OFS_TX_BUFFER_LOCAL_PRIORITY):   rd_d[7:0] = sel_ok ? local_priority_field_q[tbsel_q] : 8'h00;
      hit(avs_address, OFS_DLC):    rd_d[3:0] = sel_ok ? dlc_q[tbsel_q] : 4'h0;
      hit(avs_address, OFS_TFLG):   rd_d[NBUF-1:0] = empty_q;
      hit(avs_address, OFS_ERRCNT): rd_d[15:0] = {rec, tec};
      hit(avs_address, OFS_TSTX):
        rd_d[15:0] = (tbsel_q < 2'(NBUF)) ? ts_tx_q[tbsel_q] : 16'h0000;
      hit(avs_address, OFS_TSRX):   rd_d[15:0] = ts_rx_q;
      hit(avs_address, OFS_IRQST):  rd_d[NIRQ-1:0] = irq_st_q;
      hit(avs_address, OFS_IRQMSK): rd_d[NIRQ-1:0] = irq_msk_q;
      hit(avs_address, OFS_ARB):    rd_d[2:0] = {win_valid_q, win_idx_q};
      default: begin
        for (int i = 0; i < NACC; i++) begin
          if (hit(avs_address, OFS_IDAR + 8'(4 * i))) rd_d[7:0] = idar_q[i];
          if (hit(avs_address, OFS_IDMR + 8'(4 * i))) rd_d[7:0] = idmr_q[i];
        end
      end
    endcase
  end

  // ************************************************************
  // Mode handshakes
  // ************************************************************
  // Entry from run waits for an idle bus so a frame is never cut in half
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mode_q <= MODE_RUN;
    end else begin
      case (mode_q)
        MODE_RUN: begin
          if (ctl0_q[B_INIT_REQUEST_BIT] && proto_in.bus_idle) mode_q <= MODE_INIT;
          else if (ctl0_q[B_SLEEP_REQUEST_BIT] && proto_in.bus_idle) mode_q <= MODE_SLEEP;
        end
        MODE_INIT: if (!ctl0_q[B_INIT_REQUEST_BIT]) mode_q <= MODE_RUN;
        MODE_SLEEP: begin
          if (!ctl0_q[B_SLEEP_REQUEST_BIT] || wake) mode_q <= MODE_RUN;
          else if (ctl0_q[B_INIT_REQUEST_BIT]) mode_q <= MODE_INIT;
        end
        default: mode_q <= MODE_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctl0_q <= CTL0_RST;
    end else if (wr_en && hit(avs_address, OFS_CTL0)) begin
      ctl0_q <= avs_writedata[7:0] & CTL0_WMSK;
    end else if (wake) begin
      ctl0_q[B_SLEEP_REQUEST_BIT] <= 1'b0;
    end
  end

  // ************************************************************
  // Locked configuration
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      btr0_q <= 8'h00;
      btr1_q <= 8'h00;
      idac_q <= 8'h00;
      idar_q <= '0;
      idmr_q <= '0;
      clock_source_select_q <= 1'b0;
    end else if (wr_en && init_mode) begin
      if (hit(avs_address, OFS_BTR0)) btr0_q <= avs_writedata[7:0];
      if (hit(avs_address, OFS_BTR1)) btr1_q <= avs_writedata[7:0];
      if (hit(avs_address, OFS_IDAC)) idac_q <= avs_writedata[7:0];
      if (hit(avs_address, OFS_CTL1)) clock_source_select_q <= avs_writedata[B_CLOCK_SOURCE_SELECT];
      for (int i = 0; i < NACC; i++) begin
        if (hit(avs_address, OFS_IDAR + 8'(4 * i))) idar_q[i] <= avs_writedata[7:0];
        if (hit(avs_address, OFS_IDMR + 8'(4 * i))) idmr_q[i] <= avs_writedata[7:0];
      end
    end
  end

  // Enable takes its first write in init mode only, so a stray store cannot switch it off
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      en_q        <= 1'b0;
      en_locked_q <= 1'b0;
    end else if (wr_en && init_mode && hit(avs_address, OFS_CTL1) && !en_locked_q) begin
      en_q        <= avs_writedata[B_ENABLE];
      en_locked_q <= 1'b1;
    end
  end

  // ************************************************************
  // Transmit buffers and selection
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tbsel_q <= 2'h0;
      local_priority_field_q  <= '0;
      dlc_q   <= '0;
    end else if (wr_en) begin
      if (hit(avs_address, OFS_TBSEL)) tbsel_q <= avs_writedata[1:0];
      if (hit(avs_address, OFS_TX_BUFFER_LOCAL_PRIORITY) && sel_ok) local_priority_field_q[tbsel_q] <= avs_writedata[7:0];
      if (hit(avs_address, OFS_DLC) && sel_ok) dlc_q[tbsel_q] <= avs_writedata[3:0];
    end
  end

  // A finishing transmission sets its flag even against a same-cycle queue write
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      empty_q <= '1;
    end else begin
      for (int i = 0; i < NBUF; i++) begin
        if (proto_in.tx_done && win_valid_q && win_idx_q == 2'(i)) empty_q[i] <= 1'b1;
        else if (wr_en && hit(avs_address, OFS_TFLG) && avs_writedata[i]) empty_q[i] <= 1'b0;
      end
    end
  end

  ccp_local_priority_field_arb u_arb (
    .pend  (~empty_q),
    .local_priority_field  (local_priority_field_q),
    .valid (arb_valid),
    .idx   (arb_idx)
  );

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      win_valid_q <= 1'b0;
      win_idx_q   <= 2'h0;
    end else if (proto_in.sof_pending) begin
      win_valid_q <= arb_valid;
      win_idx_q   <= arb_idx;
    end else if (proto_in.tx_done) begin
      win_valid_q <= 1'b0;
    end
  end

  // ************************************************************
  // Quantum clock, timer and time stamps
  // ************************************************************
  ccp_quantum_gen u_tq (
    .mclk     (mclk),
    .rstn     (rstn),
    .src_bus  (clock_source_select_q),
    .osc_tick (proto_in.osc_tick),
    .prescale (btr0_q[BRP_HI:0]),
    .tq_tick  (tq_tick)
  );

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      timer_q <= 16'h0000;
    end else if (tq_tick) begin
      timer_q <= timer_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ts_tx_q <= '0;
      ts_rx_q <= 16'h0000;
    end else if (proto_in.ack_seen && ctl0_q[B_TIME]) begin
      if (!proto_in.ack_is_tx) ts_rx_q <= timer_q;
      else if (win_valid_q) ts_tx_q[win_idx_q] <= timer_q;
    end
  end

  // ************************************************************
  // Interrupts: sticky, cleared by reading, new events win
  // ************************************************************
  assign ev[IRQ_TXDONE] = proto_in.tx_done & win_valid_q;
  assign ev[IRQ_INIT]   = (mode_q != MODE_INIT) & ctl0_q[B_INIT_REQUEST_BIT] & proto_in.bus_idle;
  assign ev[IRQ_SLEEP]  = (mode_q == MODE_RUN) & ~ctl0_q[B_INIT_REQUEST_BIT] & ctl0_q[B_SLEEP_REQUEST_BIT]
                        & proto_in.bus_idle;
  assign ev[IRQ_WAKE]   = wake;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq_st_q  <= '0;
      irq_msk_q <= '0;
    end else begin
      if (rd_done && hit(avs_address, OFS_IRQST)) irq_st_q <= (irq_st_q & ~rdata_q[NIRQ-1:0]) | ev;
      else irq_st_q <= irq_st_q | ev;
      if (wr_en && hit(avs_address, OFS_IRQMSK)) irq_msk_q <= avs_writedata[NIRQ-1:0];
    end
  end
  assign irq = |(irq_st_q & irq_msk_q);

  // ************************************************************
  // Pin and engine outputs
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      txpin_q <= 1'b1;
    end else begin
      txpin_q <= (ctl0_q[B_INIT_REQUEST_BIT] || mode_q != MODE_RUN || !en_q) ? 1'b1 : proto_in.tx_bit;
    end
  end
  assign bus_transmit_pin      = txpin_q;
  assign proto_out.sel_valid   = win_valid_q;
  assign proto_out.sel_idx     = win_idx_q;
  assign proto_out.byte_count  = dlc_bytes(dlc_q[win_idx_q]);
  assign proto_out.sjw_tq      = {1'b0, btr0_q[SJW_HI:SJW_LO]} + 3'h1;
  assign proto_out.tq_tick     = tq_tick;
  assign proto_out.ctl_enabled = en_q;
  // Error counters live in the engine; this side only mirrors them for reads

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_init_ack_cause: assert property ($rose(mode_q == MODE_INIT) |-> $past(ctl0_q[B_INIT_REQUEST_BIT]))
    else $error("init ack without request");
  a_sleep_wake_exit: assert property (wake |=> mode_q == MODE_RUN && !ctl0_q[B_SLEEP_REQUEST_BIT])
    else $error("sleep held after wake-up activity");
  a_config_lock: assert property (wr_en && !init_mode |=> $stable(btr0_q) && $stable(idar_q))
    else $error("locked register changed outside init");
  a_btr0_write: assert property (wr_en && init_mode && hit(avs_address, OFS_BTR0)
    |=> btr0_q == $past(avs_writedata[7:0]))
    else $error("timing write lost in init");
  a_jump_width: assert property (btr0_q[SJW_HI:SJW_LO] == 2'h3 |-> proto_out.sjw_tq == 3'h4)
    else $error("jump width decode wrong");
  a_length_code: assert property (dlc_q[win_idx_q] <= DLC_MAX
    |-> proto_out.byte_count == dlc_q[win_idx_q])
    else $error("length code decode wrong");
  a_sof_capture: assert property (proto_in.sof_pending |=> win_valid_q == $past(~&empty_q))
    else $error("pending buffer missed at frame start");
  a_local_priority_field_guard: assert property (wr_en && !sel_ok |=> $stable(local_priority_field_q))
    else $error("priority written while buffer busy");
  a_stamp_rx: assert property (proto_in.ack_seen && ctl0_q[B_TIME] && !proto_in.ack_is_tx
    |=> ts_rx_q == $past(timer_q))
    else $error("receive time stamp not taken");
  a_err_mirror: assert property (rd_done && hit(avs_address, OFS_ERRCNT)
    |-> avs_readdata[15:0] == $past({rec, tec}))
    else $error("error counter read wrong");
  a_txpin_force: assert property (mode_q != MODE_RUN |=> bus_transmit_pin)
    else $error("transmit pin not recessive");
  a_enable_once: assert property (en_locked_q |=> $stable(en_q))
    else $error("enable changed after its write");
  a_lowest_wins: assert property (arb_valid |->
    (local_priority_field_q[arb_idx] <= local_priority_field_q[0] || empty_q[0]) && (local_priority_field_q[arb_idx] <= local_priority_field_q[1] || empty_q[1])
    && (local_priority_field_q[arb_idx] <= local_priority_field_q[2] || empty_q[2]))
    else $error("winner does not hold the smallest priority");

  c_init_entry: cover property ($rose(mode_q == MODE_INIT));
  c_wake_up: cover property (wake);
  c_local_priority_field_tie: cover property (proto_in.sof_pending && arb_valid && local_priority_field_q[0] == local_priority_field_q[1]
    && ~|empty_q[1:0]);
endmodule : ccp_ctrl
`default_nettype wire

// [tb/ccp_proto_model.sv]
// Far-side protocol engine model feeding the block's protocol inputs
`timescale 1ns/100ps
`default_nettype none
module ccp_proto_model (
  input  wire logic                  mclk,
  output var ccp_pkg::ccp_proto_in_t proto_in,
  output var logic [7:0]             tec,
  output var logic [7:0]             rec
);
  import ccp_pkg::*;
  // Counters belong to the protocol side; software only ever sees them
  initial begin
    proto_in = '0;
    proto_in.bus_idle = 1'b1;
    tec = 8'h5A;
    rec = 8'h3C;
  end
  // Oscillator ticks at a fixed period, so the source stays in tolerance
  always @(posedge mclk) begin
    proto_in.osc_tick <= ~proto_in.osc_tick;
  end
  // Counters move only with protocol events, never with register traffic
  always @(posedge mclk) begin
    if (proto_in.tx_done) tec <= tec + 8'h01;
    if (proto_in.ack_seen) rec <= rec + 8'h01;
  end
  task automatic drive(input int b, input logic v);
    @(posedge mclk);
    proto_in[b] <= v;
  endtask : drive
  task automatic pulse(input int b);
    @(posedge mclk);
    proto_in[b] <= 1'b1;
    @(posedge mclk);
    proto_in[b] <= 1'b0;
  endtask : pulse
endmodule : ccp_proto_model
`default_nettype wire

// [tb/ccp_ctrl_tb.sv]
// Self-checking bench for the CAN configuration and transmit priority block
`timescale 1ns/100ps
`default_nettype none
module ccp_ctrl_tb;
  import ccp_pkg::*;
  logic           mclk = 1'b0;
  logic           rstn = 1'b0;
  logic [7:0]     avs_address = 8'h00;
  logic           avs_read = 1'b0;
  logic           avs_write = 1'b0;
  logic [31:0]    avs_writedata = 32'h0000_0000;
  logic [31:0]    avs_readdata;
  logic           avs_waitrequest;
  ccp_proto_in_t  proto_in;
  ccp_proto_out_t proto_out;
  logic [7:0]     tec;
  logic [7:0]     rec;
  logic           bus_transmit_pin;
  logic           irq;
  logic [31:0]    rdata;
  int             n_mismatch = 0;
  int             check_count = 0;
  int             cyc = 0;
  int             n;
  // ****************************************
  // Rows: priorities of buffers 0..2, expected winner in the low byte
  // ****************************************
  localparam logic [31:0] ROWS [5] = '{32'h0503_0901, 32'h0707_0700, 32'h0802_0201,
                                      32'h0000_0100, 32'h0909_0402};
  always #5 mclk = ~mclk;
  ccp_ctrl uut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .proto_in(proto_in), .tec(tec), .rec(rec),
    .proto_out(proto_out), .bus_transmit_pin(bus_transmit_pin), .irq(irq));
  ccp_proto_model pm (.mclk(mclk), .proto_in(proto_in), .tec(tec), .rec(rec));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Request held until waitrequest is seen low; the slave sets the pace
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h00_0000, d};
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(rdata, e);
  endtask : rd
  task automatic count_ticks();
    n = 0;
    repeat (60) begin
      @(posedge mclk);
      n += proto_out.tq_tick;
    end
  endtask : count_ticks
  // Buffer 0 priority is rewritten while queued; that write must not land
  task automatic arb(input logic [31:0] row);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFS_TBSEL, i[7:0]);
      bus(1'b1, OFS_TX_BUFFER_LOCAL_PRIORITY, row[31-8*i -: 8]);
    end
    bus(1'b1, OFS_TFLG, 8'h07);
    bus(1'b1, OFS_TBSEL, 8'h00);
    bus(1'b1, OFS_TX_BUFFER_LOCAL_PRIORITY, 8'hFF);
    rd(OFS_TX_BUFFER_LOCAL_PRIORITY, 32'h0000_0000);
    pm.pulse(7);
    @(posedge mclk);
    chk({proto_out.sel_valid, proto_out.sel_idx}, {1'b1, row[1:0]});
    repeat (3) begin
      pm.pulse(4);
      pm.pulse(7);
    end
    rd(OFS_TX_BUFFER_LOCAL_PRIORITY, {24'h00_0000, row[31:24]});
  endtask : arb
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    rd(OFS_BTR0, 32'h0000_0000);
    rd(OFS_TX_BUFFER_LOCAL_PRIORITY, 32'h0000_0000);
    rd(OFS_TFLG, 32'h0000_0007);
    rd(OFS_CTL1, 32'h0000_0001);
    chk(bus_transmit_pin, 32'h0000_0001);
    for (int j = 0; j < 4; j++) begin
      bus(1'b1, OFS_BTR0, {j[1:0], 6'h05});
      @(posedge mclk);
      chk(proto_out.sjw_tq, j + 1);
    end
    rd(OFS_BTR0, 32'h0000_00C5);
    bus(1'b1, OFS_CTL1, 8'hC0);
    bus(1'b1, OFS_CTL1, 8'h40);
    rd(OFS_CTL1, 32'h0000_00C1);
    count_ticks();
    chk(n, 10);
    bus(1'b1, OFS_CTL0, 8'h00);
    rd(OFS_CTL1, 32'h0000_00C0);
    bus(1'b1, OFS_BTR0, 8'h00);
    rd(OFS_BTR0, 32'h0000_00C5);
    bus(1'b1, OFS_IDAR, 8'h77);
    rd(OFS_IDAR, 32'h0000_0000);
    chk(bus_transmit_pin, 32'h0000_0000);
    pm.drive(1, 1'b1);
    repeat (2) @(posedge mclk);
    chk(bus_transmit_pin, 32'h0000_0001);
    pm.drive(1, 1'b0);
    bus(1'b1, OFS_ERRCNT, 8'hFF);
    rd(OFS_ERRCNT, 32'h0000_3C5A);
    foreach (ROWS[r]) arb(ROWS[r]);
    // Fifteen finished frames have moved the model's transmit counter
    rd(OFS_ERRCNT, 32'h0000_3C69);
    bus(1'b1, OFS_TBSEL, 8'h00);
    for (int c = 0; c < 10; c++) begin
      bus(1'b1, OFS_DLC, c[7:0]);
      bus(1'b1, OFS_TFLG, 8'h01);
      pm.pulse(7);
      @(posedge mclk);
      chk(proto_out.byte_count, (c > 8) ? 8 : c);
      pm.pulse(4);
    end
    bus(1'b1, OFS_IRQMSK, 8'h00);
    rd(OFS_IRQST, 32'h0000_0003);
    bus(1'b1, OFS_TFLG, 8'h01);
    pm.pulse(7);
    pm.pulse(4);
    @(posedge mclk);
    chk(irq, 32'h0000_0000);
    bus(1'b1, OFS_IRQMSK, 8'h01);
    @(posedge mclk);
    chk(irq, 32'h0000_0001);
    rd(OFS_IRQST, 32'h0000_0001);
    @(posedge mclk);
    chk(irq, 32'h0000_0000);
    pm.pulse(6);
    rd(OFS_TSRX, 32'h0000_0000);
    bus(1'b1, OFS_CTL0, 8'h08);
    bus(1'b1, OFS_TFLG, 8'h01);
    pm.pulse(7);
    pm.pulse(6);
    // Sixty clocks between the two acknowledges at prescale five make ten quanta
    repeat (57) @(posedge mclk);
    pm.drive(5, 1'b1);
    pm.pulse(6);
    pm.drive(5, 1'b0);
    bus(1'b0, OFS_TSRX, 8'h00);
    n = rdata;
    bus(1'b0, OFS_TSTX, 8'h00);
    chk(rdata - n, 10);
    bus(1'b1, OFS_CTL0, 8'h06);
    repeat (3) @(posedge mclk);
    rd(OFS_CTL1, 32'h0000_00C2);
    chk(bus_transmit_pin, 32'h0000_0001);
    pm.pulse(2);
    rd(OFS_CTL1, 32'h0000_00C0);
    rd(OFS_IRQST, 32'h0000_000C);
    // Mid-run reset with a busy bus: init entry must wait until the bus is idle
    pm.drive(3, 1'b0);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(OFS_CTL1, 32'h0000_0000);
    rd(OFS_BTR0, 32'h0000_0000);
    pm.drive(3, 1'b1);
    rd(OFS_CTL1, 32'h0000_0001);
    // Oscillator source ticks every other clock; prescale zero passes it through
    count_ticks();
    chk(n, 30);
    print_verdict();
  end
endmodule : ccp_ctrl_tb
`default_nettype wire
